// ### verilog/smrc_pkg.sv
/*
  constants for the converter mute and ramp control: register map, field
  positions, reset values, ramp length and data path sizes.
  assumes one 40 MHz core clock and a one-cycle sample tick per core sample.
*/
// Function
// - bits 7..0 of the control register manually mute pairs 7..0.
// - bits 8 and 9 switch ramped muting per block on or off.
// - gain changes linearly during both mute and unmute ramps.
// - a full ramp takes exactly 2048 input samples.
// - the ramp steps once per core sample start pulse.
// - with bit 10 set, pairs losing or lacking lock mute, unless block disabled.
// - automatic lock-loss mute always ramps, never steps.
// - relocked pair unmutes by ramp if block enabled and manual mute clear.
// - manual mute overrides automatic unmute on relock.
// - block 1 disable ignores bits 7..4 and keeps pairs 7..4 active.
// - block 0 disable ignores bits 3..0 and keeps pairs 3..0 active.
// - noise may pass while a pair acquires lock; software delays unmute.
// - locked means rate set, input steady, ratio done; lock bit reads low.
package smrc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NPAIR = 8;
  localparam int PAIRS_PER_BLOCK = 4;
  // register offsets
  localparam logic [ADDR_W-1:0] LOCK_OFS = 16'hf580;
  localparam logic [ADDR_W-1:0] MUTE_OFS = 16'hf581;
  localparam logic [ADDR_W-1:0] STAT_OFS = 16'hf582;
  // field positions and reset values
  localparam int MAN_LSB = 0;
  localparam int RAMP0_BIT = 8;
  localparam int RAMP1_BIT = 9;
  localparam int AUTO_BIT = 10;
  localparam int CTRL_USED_W = 11;
  localparam logic [DATA_W-1:0] MUTE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [NPAIR-1:0] LOCK_RST = 8'h00;
  // ramp: unity gain equals the ramp length in samples
  localparam int RAMP_SAMPLES = 2048;
  localparam int GAIN_W = 12;
  localparam logic [GAIN_W-1:0] GAIN_FULL = 12'h800;
  localparam logic [GAIN_W-1:0] GAIN_ZERO = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_STEP = 12'h001;
  // data path
  localparam int SAMPLE_W = 24;
  localparam int PAIR_W = 3;
  localparam int FIFO_DEPTH = 4;
endpackage

// ### verilog/smrc_top.sv
/*
  converter mute and ramp control: control/status registers on a plain
  strobe port, per-pair linear gain ramps, lock decoding and a gained
  sample path behind a small fifo.
  assumes the lock conditions, sample tick and stream inputs come from
  logic on ref_clk, and that strobes are single cycle and never overlap.
*/
`timescale 1ns/1ps

module smrc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic push;
  logic pop;

  assign push = s_valid && s_ready;
  assign pop = m_valid && m_ready;
  assign m_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CNT_ONE;
    end else if (pop && !push) begin
      next_count = count - CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= s_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_W'(1);
      end
    end
  end

  // registered flags keep full and empty honest against the count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= '0;
      s_ready <= 1'b0;
      m_valid <= 1'b0;
    end else begin
      count <= next_count;
      s_ready <= (next_count != CNT_FULL);
      m_valid <= (next_count != '0);
    end
  end

  chk_fifo_flags: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> s_ready == (count != CNT_FULL) && m_valid == (count != '0))
    else $error("fifo flags disagree with count");
endmodule // smrc_fifo

module smrc_top
  import smrc_pkg::*;
#(
  parameter int NUM_PAIRS = NPAIR,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic core_start_pulse,
  input wire logic [NPAIR-1:0] rate_out_set,
  input wire logic [NPAIR-1:0] rate_in_steady,
  input wire logic [NPAIR-1:0] ratio_done,
  output logic [NPAIR-1:0] pair_lock_status,
  output logic [NPAIR-1:0] pair_muted,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [PAIR_W-1:0] in_pair,
  input wire logic [SAMPLE_W-1:0] in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output logic [PAIR_W-1:0] out_pair,
  output logic [SAMPLE_W-1:0] out_sample
);
  localparam int FW = PAIR_W + SAMPLE_W;

  logic [CTRL_USED_W-1:0] ctrl;
  logic [GAIN_W-1:0] gain [NPAIR];
  logic [NPAIR-1:0] mute_req;
  logic [NPAIR-1:0] blk_dis;
  logic [NPAIR-1:0] ramping;
  logic fifo_valid;
  logic fifo_ready;
  logic [FW-1:0] fifo_data;
  logic [PAIR_W-1:0] fifo_pair;
  logic signed [SAMPLE_W+GAIN_W:0] product;

  // block of a pair: pairs 3..0 block 0, pairs 7..4 block 1
  function automatic logic pair_disabled(input logic [CTRL_USED_W-1:0] c, input int n);
    pair_disabled = (n >= PAIRS_PER_BLOCK) ? c[RAMP1_BIT] : c[RAMP0_BIT];
  endfunction

  // control register; reserved bits read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= MUTE_RST[CTRL_USED_W-1:0];
    end else if (reg_wr && reg_addr == MUTE_OFS) begin
      ctrl <= reg_wdata[CTRL_USED_W-1:0];
    end
  end

  chk_ctrl_write: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == MUTE_OFS |=> ctrl == $past(reg_wdata[CTRL_USED_W-1:0]))
    else $error("control write not stored");

  // read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= RDATA_RST;
    end else if (reg_rd) begin
      unique case (reg_addr)
        LOCK_OFS: reg_rdata <= {{(DATA_W-NPAIR){1'b0}}, pair_lock_status};
        MUTE_OFS: reg_rdata <= {{(DATA_W-CTRL_USED_W){1'b0}}, ctrl};
        STAT_OFS: reg_rdata <= {ramping, pair_muted};
        default: reg_rdata <= RDATA_RST;
      endcase
    end else begin
      reg_rdata <= RDATA_RST;
    end
  end

  chk_read_ctrl: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == MUTE_OFS && !reg_wr |=> reg_rdata == {5'h00, $past(ctrl)}
    ##1 reg_rdata == RDATA_RST || $past(reg_rd))
    else $error("control read data wrong");

  chk_lock_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == LOCK_OFS |=> reg_rdata == {8'h00, $past(pair_lock_status)})
    else $error("lock status read wrong");

  chk_status_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == STAT_OFS |=> reg_rdata == $past({ramping, pair_muted}))
    else $error("status read wrong");

  // lock bit low only when all three lock conditions hold
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pair_lock_status <= LOCK_RST;
    end else begin
      pair_lock_status <= ~(rate_out_set & rate_in_steady & ratio_done);
    end
  end

  chk_lock_decode: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> pair_lock_status == ~$past(rate_out_set & rate_in_steady & ratio_done))
    else $error("lock status decode wrong");

  // per-pair gain ramps
  genvar p;
  generate
    for (p = 0; p < NPAIR; p++) begin : g_pair
      // manual wins; auto mute only when enabled; disabled block never mutes
      assign blk_dis[p] = pair_disabled(ctrl, p);
      assign mute_req[p] = !blk_dis[p] && (ctrl[MAN_LSB+p] ||
        (ctrl[AUTO_BIT] && pair_lock_status[p]));

      // one step per sample, turning round from the present gain
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          gain[p] <= GAIN_FULL;
        end else if (blk_dis[p]) begin
          gain[p] <= GAIN_FULL;
        end else if (core_start_pulse) begin
          if (mute_req[p] && gain[p] != GAIN_ZERO) begin
            gain[p] <= gain[p] - GAIN_STEP;
          end else if (!mute_req[p] && gain[p] != GAIN_FULL) begin
            gain[p] <= gain[p] + GAIN_STEP;
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pair_muted[p] <= 1'b0;
          ramping[p] <= 1'b0;
        end else begin
          pair_muted[p] <= (gain[p] == GAIN_ZERO);
          ramping[p] <= (gain[p] != GAIN_ZERO) && (gain[p] != GAIN_FULL);
        end
      end

      sequence s_tick_enabled;
        core_start_pulse && !blk_dis[p];
      endsequence

      sequence s_down_step;
        s_tick_enabled ##0 mute_req[p] && gain[p] != GAIN_ZERO;
      endsequence

      sequence s_up_step;
        s_tick_enabled ##0 !mute_req[p] && gain[p] != GAIN_FULL;
      endsequence

      chk_gain_down_step: assert property (@(posedge ref_clk) disable iff (rst)
        s_down_step |=> gain[p] == $past(gain[p]) - GAIN_STEP)
        else $error("mute ramp step not one");

      chk_gain_up_step: assert property (@(posedge ref_clk) disable iff (rst)
        s_up_step |=> gain[p] == $past(gain[p]) + GAIN_STEP)
        else $error("unmute ramp step not one");

      chk_gain_no_tick: assert property (@(posedge ref_clk) disable iff (rst)
        !core_start_pulse && !blk_dis[p] |=> $stable(gain[p]))
        else $error("gain moved without sample tick");

      chk_auto_no_step: assert property (@(posedge ref_clk) disable iff (rst)
        gain[p] == GAIN_FULL && !blk_dis[p] ##1 !blk_dis[p] |-> gain[p] >= GAIN_FULL - GAIN_STEP)
        else $error("gain jumped instead of ramping");

      chk_auto_off_hold: assert property (@(posedge ref_clk) disable iff (rst)
        s_tick_enabled ##0 !ctrl[AUTO_BIT] && !ctrl[MAN_LSB+p] && gain[p] == GAIN_FULL |=> gain[p] == GAIN_FULL)
        else $error("muted with auto mute off");

      chk_manual_priority: assert property (@(posedge ref_clk) disable iff (rst)
        s_tick_enabled ##0 ctrl[MAN_LSB+p] && !pair_lock_status[p] && gain[p] != GAIN_ZERO
        |=> gain[p] == $past(gain[p]) - GAIN_STEP)
        else $error("manual mute lost to relock");

      chk_block_disable: assert property (@(posedge ref_clk) disable iff (rst)
        blk_dis[p] |=> gain[p] == GAIN_FULL)
        else $error("disabled block not at full gain");

      chk_muted_flag: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> pair_muted[p] == ($past(gain[p]) == GAIN_ZERO)
        && ramping[p] == ($past(gain[p]) != GAIN_ZERO && $past(gain[p]) != GAIN_FULL))
        else $error("muted flag does not follow gain");
    end
  endgenerate

  // samples pass a fifo and pick up their pair's gain on the way out
  assign fifo_pair = fifo_data[FW-1 -: PAIR_W];
  assign fifo_ready = !out_valid || out_ready;
  assign product = $signed(fifo_data[SAMPLE_W-1:0]) * $signed({1'b0, gain[fifo_pair]});

  smrc_fifo #(
    .WIDTH(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_valid(in_valid),
    .s_ready(in_ready),
    .s_data({in_pair, in_sample}),
    .m_valid(fifo_valid),
    .m_ready(fifo_ready),
    .m_data(fifo_data)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_pair <= '0;
      out_sample <= '0;
    end else if (fifo_ready) begin
      out_valid <= fifo_valid;
      if (fifo_valid) begin
        out_pair <= fifo_pair;
        out_sample <= product[GAIN_W-1 +: SAMPLE_W];
      end
    end
  end

  chk_out_hold: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_sample) && $stable(out_pair))
    else $error("output changed while stalled");
endmodule // smrc_top

// ### tb/src_mute_ramp_control_bench.sv
/*
  self-checking bench for the converter mute and ramp control top level.
  assumes the package constants and a 40 MHz ref_clk; assertions live in the design files.
*/
`timescale 1ns/1ps

module src_mute_ramp_control_bench;
  import smrc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, core_start_pulse = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 16'h0000;
  logic [DATA_W-1:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic [NPAIR-1:0] rate_out_set = 8'hff, rate_in_steady = 8'hff, ratio_done = 8'hff;
  logic [NPAIR-1:0] pair_lock_status, pair_muted;
  logic in_valid = 1'b0, in_ready, out_valid, out_ready = 1'b0;
  logic [PAIR_W-1:0] in_pair = 3'h0, out_pair;
  logic [SAMPLE_W-1:0] in_sample = 24'h000000, out_sample;
  int err_count = 0, compares = 0, cycles = 0;

  smrc_top smrc_top_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_start_pulse(core_start_pulse),
    .rate_out_set(rate_out_set), .rate_in_steady(rate_in_steady), .ratio_done(ratio_done),
    .pair_lock_status(pair_lock_status), .pair_muted(pair_muted), .in_valid(in_valid),
    .in_ready(in_ready), .in_pair(in_pair), .in_sample(in_sample), .out_valid(out_valid),
    .out_ready(out_ready), .out_pair(out_pair), .out_sample(out_sample));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // n back-to-back sample ticks, then let gain and muted flag settle
  task automatic tick(input int n);
    @(posedge ref_clk);
    if (n > 0) begin
      core_start_pulse <= 1'b1;
      repeat (n) @(posedge ref_clk);
      core_start_pulse <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // fill with out_ready low until full, then drain; word i of s comes out as e + i
  task automatic stream(input int lim, input logic [2:0] p, input logic [23:0] s, input logic [23:0] e);
    int n, k;
    n = 0;
    k = 0;
    @(posedge ref_clk);
    out_ready <= 1'b0;
    in_valid <= 1'b1;
    in_pair <= p;
    in_sample <= s;
    for (int c = 0; c < 40; c++) begin
      @(posedge ref_clk);
      if (out_valid === 1'b1 && out_ready) begin
        chk("out_pair", p, out_pair);
        chk("out_sample", e + k, out_sample);
        k++;
      end
      if (in_valid && in_ready === 1'b1) begin
        n++;
        if (n == lim) in_valid <= 1'b0;
        in_sample <= s + n;
      end
      if (c == 12) begin
        chk("words held", (lim < FIFO_DEPTH + 1) ? lim : FIFO_DEPTH + 1, n);
        out_ready <= 1'b1;
      end
    end
    chk("words out", lim, k);
  endtask

  task automatic t_regs;
    rd(MUTE_OFS, rv);
    chk("ctrl reset", 16'h0000, rv);
    wr(MUTE_OFS, 16'hffff);
    rd(MUTE_OFS, rv);
    chk("ctrl rw", 16'h07ff, rv);
    wr(16'h1234, 16'h0001);
    rd(16'h1234, rv);
    chk("unmapped", 16'h0000, rv);
    wr(MUTE_OFS, 16'h0000);
    rd(MUTE_OFS, rv);
    chk("ctrl clear", 16'h0000, rv);
    $display("test regs done");
  endtask

  task automatic t_lock;
    for (int c = 0; c < 3; c++) begin
      @(posedge ref_clk);
      rate_out_set[3] <= (c != 0);
      rate_in_steady[3] <= (c != 1);
      ratio_done[3] <= (c != 2);
      repeat (3) @(posedge ref_clk);
      chk("lock one missing", 8'h08, pair_lock_status);
    end
    rd(LOCK_OFS, rv);
    chk("lock reg", 16'h0008, rv);
    @(posedge ref_clk);
    ratio_done[3] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("lock all set", 8'h00, pair_lock_status);
    $display("test lock done");
  endtask

  task automatic t_ramp;
    wr(MUTE_OFS, 16'h0001);
    tick(1024);
    rd(STAT_OFS, rv);
    chk("status ramping", 16'h0100, rv);
    stream(1, 3'h0, 24'h100000, 24'h080000);
    wr(MUTE_OFS, 16'h0000);
    tick(512);
    stream(1, 3'h0, 24'h100000, 24'h0c0000);
    tick(512);
    wr(MUTE_OFS, 16'h0001);
    tick(2047);
    chk("muted early", 8'h00, pair_muted);
    tick(1);
    chk("muted at 2048", 8'h01, pair_muted);
    rd(STAT_OFS, rv);
    chk("status muted", 16'h0001, rv);
    wr(MUTE_OFS, 16'h0000);
    tick(2048);
    stream(8, 3'h1, 24'h000010, 24'h000010);
    $display("test ramp done");
  endtask

  task automatic t_auto;
    @(posedge ref_clk);
    ratio_done[2] <= 1'b0;
    tick(2048);
    chk("auto off", 8'h00, pair_muted);
    wr(MUTE_OFS, 16'h0400);
    tick(2047);
    chk("auto ramping", 8'h00, pair_muted);
    tick(1);
    chk("auto muted", 8'h04, pair_muted);
    @(posedge ref_clk);
    ratio_done[2] <= 1'b1;
    tick(2048);
    chk("auto unmute", 8'h00, pair_muted);
    wr(MUTE_OFS, 16'h0404);
    ratio_done[2] <= 1'b0;
    tick(2048);
    @(posedge ref_clk);
    ratio_done[2] <= 1'b1;
    tick(2048);
    chk("manual holds", 8'h04, pair_muted);
    wr(MUTE_OFS, 16'h0504);
    tick(0);
    chk("block0 off", 8'h00, pair_muted);
    wr(MUTE_OFS, 16'h06f0);
    ratio_done[6] <= 1'b0;
    tick(2048);
    chk("block1 off", 8'h00, pair_muted);
    wr(MUTE_OFS, 16'h00f0);
    tick(2048);
    chk("block1 on", 8'hf0, pair_muted);
    $display("test auto done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("muted reset", 8'h00, pair_muted);
    t_regs();
    t_lock();
    t_ramp();
    t_auto();
    complete_run();
  end
endmodule // src_mute_ramp_control_bench
